// ===== phb_pkg.sv
// package for the parallel host byte port: modes, widths, status bit layout
// assumes a single 40 MHz core clock domain
package phb_pkg;
  localparam int unsigned BUS_W         = 8;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned FIFO_DEPTH    = 32;
  localparam int unsigned CORE_CLK_MHZ  = 40;
  // status byte bit positions
  localparam int unsigned ST_IN_FULL    = 0;
  localparam int unsigned ST_OUT_EMPTY  = 1;
  localparam int unsigned ST_FIFO_EMPTY = 2;
  localparam int unsigned ST_FIFO_FULL  = 3;
  localparam int unsigned ST_MODE       = 4;
  localparam int unsigned ST_LANE       = 5;
  // reset values of the flags and of the bus drive byte
  localparam logic        RST_IN_FULL   = 1'b0;
  localparam logic        RST_OUT_EMPTY = 1'b1;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  typedef enum logic { PHB_MODE_STROBE_PAIR, PHB_MODE_RW_STROBE } phb_mode_e;
endpackage : phb_pkg

// ===== phb_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module phb_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             i_core_clk, // core clock
  input  wire logic             i_reset,    // async reset
  input  wire logic [WIDTH-1:0] i_wr_data,  // fill data
  input  wire logic             i_wr_valid, // fill request
  output logic                  o_wr_ready, // space available
  output logic      [WIDTH-1:0] o_rd_data,  // head word
  output logic                  o_rd_valid, // word available
  input  wire logic             i_rd_ready  // drain accept
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              do_wr = i_wr_valid && o_wr_ready;
  wire              do_rd = o_rd_valid && i_rd_ready;

  // honest flags from the count
  assign o_wr_ready = (count_ff != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign o_rd_valid = (count_ff != '0);
  assign o_rd_data  = mem[rd_ptr_ff];

  // storage write
  always_ff @(posedge i_core_clk) begin
    if (do_wr) mem[wr_ptr_ff] <= i_wr_data;
  end

  // pointers and occupancy
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_wr) wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (do_rd) rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : phb_fifo

// ===== phb_host_port.sv
// parallel host byte port: host byte bus in and out, flags, pin sharing
// assumes host pins are asynchronous (synchronised here); dsp side on i_core_clk
`timescale 1ns/1ps
module phb_host_port #(
  parameter int unsigned FIFO_DEPTH = phb_pkg::FIFO_DEPTH
) (
  input  wire logic        i_core_clk,          // 40 MHz core clock
  input  wire logic        i_reset,             // async reset, active high
  input  wire logic [7:0]  i_host_byte_bus,     // bus level from pins
  output logic      [7:0]  o_host_byte_bus,     // bus drive value
  output logic      [7:0]  o_host_byte_bus_oe_n,// drive enable, low drives
  input  wire logic        i_host_chip_select_n,// chip select, active low
  input  wire logic        i_byte_lane_select,  // 1 high byte, 0 low byte
  input  wire logic        i_status_select,     // 1 status, 0 data
  input  wire logic        i_input_strobe,      // write strobe / read-write-n
  input  wire logic        i_output_strobe,     // read strobe / data strobe
  output logic             o_input_full_flag,   // input full pin
  output logic             o_output_empty_flag, // output empty pin
  input  wire logic        i_rw_strobe_mode,    // 1 rw-strobe protocol
  input  wire logic        i_data_strobe_high,  // data strobe active high
  input  wire logic        i_full_or_empty,     // full pin carries or
  input  wire logic        i_serial2_pin_enable,// 1 pins to second serial port
  input  wire logic [3:0]  i_serial2_out,       // serial port drive, low pins
  input  wire logic [3:0]  i_serial2_oe_n,      // serial port enables
  input  wire logic [3:0]  i_bit_io_out,        // bit lines drive, high pins
  input  wire logic [3:0]  i_bit_io_oe_n,       // bit line enables
  output logic [15:0]      o_dsp_in_data,       // fifo head word to dsp
  output logic             o_dsp_in_valid,      // word waiting
  input  wire logic        i_dsp_in_read,       // dsp reads input buffer
  input  wire logic [15:0] i_dsp_out_data,      // dsp output word
  input  wire logic        i_dsp_out_write,     // dsp writes output buffer
  output logic             o_in_fifo_ready      // fifo can take a word
);
  // two-flop synchronisers for pins: cs, in strobe, out strobe, lane, stat
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [7:0] bus1_ff;
  logic [7:0] bus2_ff;
  logic [4:0] prev_ff;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_ff <= 5'h1f;
      sync2_ff <= 5'h1f;
      bus1_ff  <= 8'h00;
      bus2_ff  <= 8'h00;
    end else begin
      sync1_ff <= {i_status_select, i_byte_lane_select, i_output_strobe,
                   i_input_strobe, i_host_chip_select_n};
      sync2_ff <= sync1_ff;
      bus1_ff  <= i_host_byte_bus;
      bus2_ff  <= bus1_ff;
    end
  end

  wire cs_n   = sync2_ff[0];
  wire istb   = sync2_ff[1];
  wire ostb   = sync2_ff[2];
  wire lane   = sync2_ff[3];
  wire stat   = sync2_ff[4];
  wire p_cs_n = prev_ff[0];
  wire p_istb = prev_ff[1];
  wire p_ostb = prev_ff[2];
  wire p_lane = prev_ff[3];

  // history for edge detection
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) prev_ff <= 5'h1f;
    else         prev_ff <= sync2_ff;
  end

  // port active only when pins given to the host port
  wire port_on = !i_serial2_pin_enable;
  // data strobe asserted level, polarity from software
  wire ds_act   = i_data_strobe_high ? ostb : !ostb;
  wire p_ds_act = i_data_strobe_high ? p_ostb : !p_ostb;
  // access active while selected: strobe-pair or rw-strobe form
  wire wr_act   = i_rw_strobe_mode ? (ds_act && !istb) : !istb;
  wire p_wr_act = i_rw_strobe_mode ? (p_ds_act && !p_istb) : !p_istb;
  wire rd_act   = i_rw_strobe_mode ? (ds_act && istb) : !ostb;
  wire p_rd_act = i_rw_strobe_mode ? (p_ds_act && p_istb) : !p_ostb;
  wire sel      = !cs_n && port_on;
  wire p_sel    = !p_cs_n && port_on;
  // end of access: strobe deasserts or select rises, whichever first
  wire wr_end   = p_sel && p_wr_act && !(sel && wr_act);
  wire rd_end   = p_sel && p_rd_act && !(sel && rd_act);
  wire rd_live  = sel && rd_act;

  // host data buffer: two byte lanes, bytes gathered in the latch
  logic [15:0] in_word_ff;
  logic        lo_seen_ff;
  logic        in_full_ff;
  logic        out_empty_ff;
  logic [15:0] out_word_ff;
  logic [7:0]  drv_ff;
  logic [7:0]  oe_n_ff;
  logic        fi_full_ff;
  logic        fo_empty_ff;

  // a word is pushed once both lanes are written, high byte last
  wire        push      = wr_end && p_lane && lo_seen_ff;
  wire        fifo_rdy;
  wire [15:0] push_word = {bus2_ff, in_word_ff[7:0]};

  // capture written byte into its lane
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      in_word_ff <= 16'h0000;
      lo_seen_ff <= 1'b0;
    end else if (wr_end) begin
      if (p_lane) in_word_ff[15:8] <= bus2_ff;
      else        in_word_ff[7:0]  <= bus2_ff;
      lo_seen_ff <= !p_lane;
    end
  end

  phb_fifo #(
    .WIDTH (phb_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_in_fifo (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_wr_data  (push_word),
    .i_wr_valid (push),
    .o_wr_ready (fifo_rdy),
    .o_rd_data  (o_dsp_in_data),
    .o_rd_valid (o_dsp_in_valid),
    .i_rd_ready (i_dsp_in_read)
  );

  // input full: set on capture, cleared by dsp read, set wins
  wire dsp_take = i_dsp_in_read && o_dsp_in_valid;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset)       in_full_ff <= phb_pkg::RST_IN_FULL;
    else if (wr_end)   in_full_ff <= 1'b1;
    else if (dsp_take) in_full_ff <= 1'b0;
  end

  // output empty: set after host read of high byte, cleared by dsp write
  wire rd_word_done = rd_end && p_lane && !stat;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      out_empty_ff <= phb_pkg::RST_OUT_EMPTY;
      out_word_ff  <= 16'h0000;
    end else begin
      if (i_dsp_out_write) out_word_ff <= i_dsp_out_data;
      if (rd_word_done)         out_empty_ff <= 1'b1;
      else if (i_dsp_out_write) out_empty_ff <= 1'b0;
    end
  end
  // status byte and read data selection
  wire [7:0] status_byte = {2'b00, lane, i_rw_strobe_mode, !fifo_rdy,
                            !o_dsp_in_valid, out_empty_ff, in_full_ff};
  wire [7:0] data_byte   = lane ? out_word_ff[15:8] : out_word_ff[7:0];
  wire [7:0] read_byte   = stat ? status_byte : data_byte;

  // pin drive: host port when enabled, else serial low nibble, bit lines high
  wire [7:0] nxt_drv  = port_on ? read_byte : {i_bit_io_out, i_serial2_out};
  wire [7:0] nxt_oe_n = port_on ? {8{!rd_live}} : {i_bit_io_oe_n, i_serial2_oe_n};
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      drv_ff  <= phb_pkg::RST_BYTE;
      oe_n_ff <= 8'hff;
    end else begin
      drv_ff  <= nxt_drv;
      oe_n_ff <= nxt_oe_n;
    end
  end

  // flag pins, optional or of both flags
  wire nxt_full_pin = i_full_or_empty ? (in_full_ff || out_empty_ff) : in_full_ff;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      fi_full_ff  <= phb_pkg::RST_IN_FULL;
      fo_empty_ff <= phb_pkg::RST_OUT_EMPTY;
    end else begin
      fi_full_ff  <= nxt_full_pin;
      fo_empty_ff <= out_empty_ff;
    end
  end
  logic rdy_ff;
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) rdy_ff <= 1'b0;
    else         rdy_ff <= fifo_rdy;
  end

  assign o_host_byte_bus      = drv_ff;
  assign o_host_byte_bus_oe_n = oe_n_ff;
  assign o_input_full_flag    = fi_full_ff;
  assign o_output_empty_flag  = fo_empty_ff;
  assign o_in_fifo_ready      = rdy_ff;

  // assertions
  property p_full_set;
    @(posedge i_core_clk) disable iff (i_reset) wr_end |=> in_full_ff;
  endproperty
  a_full_set: assert property (p_full_set) else $error("input full not set");
  property p_full_clr;
    @(posedge i_core_clk) disable iff (i_reset) (dsp_take && !wr_end) |=> !in_full_ff;
  endproperty
  a_full_clr: assert property (p_full_clr) else $error("input full not cleared");
  property p_empty_set;
    @(posedge i_core_clk) disable iff (i_reset) rd_word_done |=> out_empty_ff;
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("output empty not set");
  property p_empty_clr;
    @(posedge i_core_clk) disable iff (i_reset) (i_dsp_out_write && !rd_word_done) |=> !out_empty_ff;
  endproperty
  a_empty_clr: assert property (p_empty_clr) else $error("output empty not cleared");
  property p_float;
    @(posedge i_core_clk) disable iff (i_reset) (port_on && !rd_live) |=> (o_host_byte_bus_oe_n == 8'hff);
  endproperty
  a_float: assert property (p_float) else $error("bus driven outside read");
  property p_cs_ignore;
    @(posedge i_core_clk) disable iff (i_reset) (cs_n && p_cs_n) |-> !(wr_end || rd_end);
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) else $error("strobe seen without select");
  property p_or_pin;
    @(posedge i_core_clk) disable iff (i_reset)
      (i_full_or_empty && out_empty_ff) |=> o_input_full_flag;
  endproperty
  a_or_pin: assert property (p_or_pin) else $error("or option not on pin");
  property p_stat_out;
    @(posedge i_core_clk) disable iff (i_reset)
      (port_on && rd_live && stat) |=> (o_host_byte_bus[1:0] == $past({out_empty_ff, in_full_ff}));
  endproperty
  a_stat_out: assert property (p_stat_out) else $error("status byte wrong");

  // low lane takes the synchronised bus byte
  property p_lo_capture;
    @(posedge i_core_clk) disable iff (i_reset)
      (wr_end && !p_lane) |=> (in_word_ff[7:0] == $past(bus2_ff));
  endproperty
  a_lo_capture: assert property (p_lo_capture) else $error("low byte not captured");

  // high lane takes the synchronised bus byte
  property p_hi_capture;
    @(posedge i_core_clk) disable iff (i_reset)
      (wr_end && p_lane) |=> (in_word_ff[15:8] == $past(bus2_ff));
  endproperty
  a_hi_capture: assert property (p_hi_capture) else $error("high byte not captured");

  // high byte closes the pair
  property p_pair_clear;
    @(posedge i_core_clk) disable iff (i_reset)
      (wr_end && p_lane) |=> !lo_seen_ff;
  endproperty
  a_pair_clear: assert property (p_pair_clear) else $error("pair not closed");

  // data read of low lane drives the output word
  property p_data_lo;
    @(posedge i_core_clk) disable iff (i_reset)
      (port_on && rd_live && !stat && !lane) |=> (o_host_byte_bus == $past(out_word_ff[7:0]));
  endproperty
  a_data_lo: assert property (p_data_lo) else $error("low data byte wrong");

  // data read of high lane drives the output word
  property p_data_hi;
    @(posedge i_core_clk) disable iff (i_reset)
      (port_on && rd_live && !stat && lane) |=> (o_host_byte_bus == $past(out_word_ff[15:8]));
  endproperty
  a_data_hi: assert property (p_data_hi) else $error("high data byte wrong");

  // selected read drives every bus bit
  property p_drive_read;
    @(posedge i_core_clk) disable iff (i_reset)
      (port_on && rd_live) |=> (o_host_byte_bus_oe_n == 8'h00);
  endproperty
  a_drive_read: assert property (p_drive_read) else $error("bus not driven in read");

  // serial and bit lines own the pins when enabled
  property p_serial_pins;
    @(posedge i_core_clk) disable iff (i_reset)
      !port_on |=> (o_host_byte_bus_oe_n == $past({i_bit_io_oe_n, i_serial2_oe_n}));
  endproperty
  a_serial_pins: assert property (p_serial_pins) else $error("shared pin enables wrong");

  // no host access while pins are given away
  property p_serial_quiet;
    @(posedge i_core_clk) disable iff (i_reset)
      !port_on |-> !(wr_end || rd_end);
  endproperty
  a_serial_quiet: assert property (p_serial_quiet) else $error("access while pins shared");

  // input full holds without set or clear
  property p_full_hold;
    @(posedge i_core_clk) disable iff (i_reset)
      (!wr_end && !dsp_take) |=> (in_full_ff == $past(in_full_ff));
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("input full changed alone");

  // output empty holds without set or clear
  property p_empty_hold;
    @(posedge i_core_clk) disable iff (i_reset)
      (!rd_word_done && !i_dsp_out_write) |=> (out_empty_ff == $past(out_empty_ff));
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("output empty changed alone");

  // full pin follows the flag alone without the option
  property p_plain_pin;
    @(posedge i_core_clk) disable iff (i_reset)
      !i_full_or_empty |=> (o_input_full_flag == $past(in_full_ff));
  endproperty
  a_plain_pin: assert property (p_plain_pin) else $error("full pin not plain flag");

  // option still shows input full itself
  property p_or_full;
    @(posedge i_core_clk) disable iff (i_reset)
      (i_full_or_empty && in_full_ff) |=> o_input_full_flag;
  endproperty
  a_or_full: assert property (p_or_full) else $error("or option lost full");

  // empty pin follows its flag
  property p_empty_pin;
    @(posedge i_core_clk) disable iff (i_reset)
      1'b1 |=> (o_output_empty_flag == $past(out_empty_ff));
  endproperty
  a_empty_pin: assert property (p_empty_pin) else $error("empty pin not flag");

  // status byte upper fields: lane and protocol
  property p_status_hi;
    @(posedge i_core_clk) disable iff (i_reset)
      (port_on && rd_live && stat) |=> (o_host_byte_bus[5:4] == $past({lane, i_rw_strobe_mode}));
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status upper bits wrong");

  // bus floats while chip select is high
  property p_cs_float;
    @(posedge i_core_clk) disable iff (i_reset)
      (port_on && cs_n) |=> (o_host_byte_bus_oe_n == 8'hff);
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("bus driven without select");
endmodule : phb_host_port

// ===== phb_host_model.sv
// host processor model on the byte bus side of the host port
// assumes the bench calls idle and access; enables resolve the wire here
`timescale 1ns/1ps
module phb_host_model (
  input  wire logic       i_core_clk, // pacing clock
  input  wire logic [7:0] i_dev_bus,  // device drive value
  input  wire logic [7:0] i_dev_oe_n, // device enables, low drives
  input  wire logic       i_rw_mode,  // rw-strobe protocol
  input  wire logic       i_ds_high,  // data strobe active high
  output logic      [7:0] o_bus,      // resolved wire level
  output logic            o_cs_n,     // chip select
  output logic            o_lane,     // lane select
  output logic            o_status,   // status select
  output logic            o_in_stb,   // write strobe or rw-n
  output logic            o_out_stb   // read strobe or data strobe
);
  logic [7:0] drv = 8'h00;    // host drive value
  logic       drv_en = 1'b0;  // host drives the bus
  logic [7:0] last = 8'h00;   // previous wire level
  // undriven bits show the inverse of the last level
  assign o_bus = (~i_dev_oe_n & i_dev_bus) | (i_dev_oe_n & (drv_en ? drv : ~last));
  always @(posedge i_core_clk) last <= o_bus;
  // pins idle at time zero
  initial begin
    o_cs_n = 1'b1;
    o_lane = 1'b0;
    o_status = 1'b0;
    o_in_stb = 1'b1;
    o_out_stb = 1'b1;
  end
  // idle levels for the current protocol
  task automatic idle();
    o_cs_n <= 1'b1;
    o_in_stb <= 1'b1;
    o_out_stb <= i_rw_mode ? ~i_ds_high : 1'b1;
    drv_en <= 1'b0;
  endtask : idle
  // one host cycle: select, strobe, hold, sample, end strobe, release
  task automatic access(input logic cs_n, input logic wr, input logic lane, input logic st,
                        input logic [7:0] wd, output logic [7:0] rd);
    @(posedge i_core_clk);
    o_cs_n <= cs_n;
    o_lane <= lane;
    o_status <= st;
    drv <= wd;
    drv_en <= wr;
    if (i_rw_mode) o_in_stb <= ~wr;
    @(posedge i_core_clk);
    if (i_rw_mode) o_out_stb <= i_ds_high;
    else if (wr) o_in_stb <= 1'b0;
    else o_out_stb <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    rd = o_bus;
    o_out_stb <= i_rw_mode ? ~i_ds_high : 1'b1;
    if (!i_rw_mode) o_in_stb <= 1'b1;
    @(posedge i_core_clk);
    idle();
    repeat (4) @(posedge i_core_clk);
  endtask : access
endmodule : phb_host_model

// ===== tb.sv
// bench for the host byte port: host model on the pins, dsp side driven here
// assumes the host model spaces every host cycle well past three clocks
`timescale 1ns/1ps
module tb;
  typedef struct packed { logic rw; logic dsh; logic [15:0] word; } phb_row_s;
  logic        clk = 1'b0, rst = 1'b1, rwm = 1'b0, dsh = 1'b0, foe = 1'b0, s2en = 1'b0;
  logic        dread = 1'b0, dwrite = 1'b0, cs_n, lane, st, istb, ostb, full, empty, dvalid, rdy;
  logic [7:0]  bus, dbus, doe_n, rd;
  logic [3:0]  s2o = 4'h0, s2oe_n = 4'hf, bo = 4'h0, boe_n = 4'hf;
  logic [15:0] din, dout = 16'h0000;
  int          failures = 0, n_tests = 0, n;
  phb_row_s    rows [4] = '{'{1'b0, 1'b0, 16'h1234}, '{1'b0, 1'b1, 16'h00ff},
                            '{1'b1, 1'b0, 16'ha55a}, '{1'b1, 1'b1, 16'hff00}};
  // 40 MHz core clock
  always #12.5 clk = ~clk;
  phb_host_port #(.FIFO_DEPTH(phb_pkg::FIFO_DEPTH)) dut (
    .i_core_clk(clk), .i_reset(rst), .i_host_byte_bus(bus), .o_host_byte_bus(dbus),
    .o_host_byte_bus_oe_n(doe_n), .i_host_chip_select_n(cs_n), .i_byte_lane_select(lane),
    .i_status_select(st), .i_input_strobe(istb), .i_output_strobe(ostb),
    .o_input_full_flag(full), .o_output_empty_flag(empty), .i_rw_strobe_mode(rwm),
    .i_data_strobe_high(dsh), .i_full_or_empty(foe), .i_serial2_pin_enable(s2en),
    .i_serial2_out(s2o), .i_serial2_oe_n(s2oe_n), .i_bit_io_out(bo), .i_bit_io_oe_n(boe_n),
    .o_dsp_in_data(din), .o_dsp_in_valid(dvalid), .i_dsp_in_read(dread),
    .i_dsp_out_data(dout), .i_dsp_out_write(dwrite), .o_in_fifo_ready(rdy));
  phb_host_model host (
    .i_core_clk(clk), .i_dev_bus(dbus), .i_dev_oe_n(doe_n), .i_rw_mode(rwm), .i_ds_high(dsh),
    .o_bus(bus), .o_cs_n(cs_n), .o_lane(lane), .o_status(st), .o_in_stb(istb), .o_out_stb(ostb));
  // counted compare with one line per mismatch
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // bounded wait on a flag: sel 0 input full, 1 output empty
  task automatic wait_flag(input logic sel, input logic v);
    n = 0;
    while ((sel ? empty : full) !== v && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(sel ? "output_empty_flag" : "input_full_flag", 16'(v), 16'(sel ? empty : full));
    if (n >= 40) report_and_stop();
  endtask : wait_flag
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // reset, table of word transfers, then the awkward cases
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("input_full_flag", 16'h0, 16'(full));
    chk("output_empty_flag", 16'h1, 16'(empty));
    chk("bus_oe_n", 16'hff, 16'(doe_n));
    $display("test reset done");
    foreach (rows[i]) begin
      rwm <= rows[i].rw;
      dsh <= rows[i].dsh;
      @(posedge clk);
      host.idle();
      host.access(1'b0, 1'b1, 1'b0, 1'b0, rows[i].word[7:0], rd);
      host.access(1'b0, 1'b1, 1'b1, 1'b0, rows[i].word[15:8], rd);
      wait_flag(1'b0, 1'b1);
      chk("dsp_in_data", rows[i].word, din);
      dread <= 1'b1;
      @(posedge clk);
      dread <= 1'b0;
      wait_flag(1'b0, 1'b0);
      dout <= ~rows[i].word;
      dwrite <= 1'b1;
      @(posedge clk);
      dwrite <= 1'b0;
      wait_flag(1'b1, 1'b0);
      host.access(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, rd);
      chk("read_low", {8'h00, ~rows[i].word[7:0]}, 16'(rd));
      chk("output_empty_flag", 16'h0, 16'(empty));
      host.access(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, rd);
      chk("read_high", {8'h00, ~rows[i].word[15:8]}, 16'(rd));
      wait_flag(1'b1, 1'b1);
    end
    $display("test rows done");
    host.access(1'b1, 1'b1, 1'b0, 1'b0, 8'h5a, rd);
    host.access(1'b1, 1'b1, 1'b1, 1'b0, 8'ha5, rd);
    chk("input_full_flag", 16'h0, 16'(full));
    chk("dsp_in_valid", 16'h0, 16'(dvalid));
    host.access(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, rd);
    chk("status", 16'h16, {11'h000, rd[4:0]});
    chk("bus_oe_n", 16'hff, 16'(doe_n));
    foe <= 1'b1;
    wait_flag(1'b0, 1'b1);
    foe <= 1'b0;
    wait_flag(1'b0, 1'b0);
    rwm <= 1'b0;
    @(posedge clk);
    host.idle();
    for (int i = 0; i < 33; i++) begin
      host.access(1'b0, 1'b1, 1'b0, 1'b0, 8'h3c, rd);
      host.access(1'b0, 1'b1, 1'b1, 1'b0, 8'(i), rd);
    end
    chk("fifo_ready", 16'h0, 16'(rdy));
    n = 0;
    while (dvalid === 1'b1 && n < 40) begin
      chk("drain_word", {8'(n), 8'h3c}, din);
      dread <= 1'b1;
      @(posedge clk);
      dread <= 1'b0;
      @(posedge clk);
      n++;
    end
    chk("drain_count", 16'(phb_pkg::FIFO_DEPTH), 16'(n));
    s2o <= 4'ha;
    s2oe_n <= 4'h0;
    bo <= 4'h5;
    boe_n <= 4'h3;
    s2en <= 1'b1;
    repeat (4) @(posedge clk);
    chk("pin_oe_n", 16'h30, 16'(doe_n));
    chk("pin_drive", 16'h4a, 16'(dbus & ~doe_n));
    host.access(1'b0, 1'b1, 1'b1, 1'b0, 8'h77, rd);
    chk("dsp_in_valid", 16'h0, 16'(dvalid));
    $display("test awkward done");
    report_and_stop();
  end
endmodule : tb
